// ===== src/rtcb_defines.svh
`ifndef RTCB_DEFINES_SVH
`define RTCB_DEFINES_SVH
// ****************************************************
// window base and register byte offsets
// ****************************************************
`define RTCB_BASE      32'h4000_2800
`define RTCB_OFS_TIME  10'h000
`define RTCB_OFS_DATE  10'h004
`define RTCB_OFS_CTRL  10'h008
`define RTCB_OFS_STAT  10'h00c
`define RTCB_OFS_SSEC  10'h010
`define RTCB_OFS_ALRM  10'h014
`define RTCB_OFS_SHFT  10'h018
`define RTCB_OFS_CALR  10'h01c
`define RTCB_OFS_TST   10'h020
`define RTCB_OFS_TSD   10'h024
`define RTCB_OFS_BKP0  10'h050
`define RTCB_OFS_BKPE  10'h064
`define RTCB_BKP_NUM   5
// ****************************************************
// field positions
// ****************************************************
`define RTCB_C_FMT12   0
`define RTCB_C_ALEN    1
`define RTCB_C_REFEN   2
`define RTCB_C_REF60   3
`define RTCB_C_TPEN    4
`define RTCB_C_TPLVL   6
`define RTCB_C_TSEN    8
`define RTCB_C_TSTP    9
`define RTCB_C_FILT    10
`define RTCB_C_WAKE    12
`define RTCB_S_ALRM    0
`define RTCB_S_TS      1
`define RTCB_S_TAMP    2
`define RTCB_S_BUSY    4
`define RTCB_S_TSOV    5
`define RTCB_A_MSEC    7
`define RTCB_A_MMIN    15
`define RTCB_A_MHR     23
`define RTCB_A_MDAT    30
`define RTCB_SH_ADVB   31
// ****************************************************
// reset values and timing
// ****************************************************
`define RTCB_CTRL_RST  15'h0000
`define RTCB_DATE_RST  22'h00_0841
`define RTCB_CLK_NS    100
`define RTCB_TICK_NS   10_000_000
`define RTCB_PPM_WIN   1_000_000
`define RTCB_REF50_N   6'd49
`define RTCB_REF60_N   6'd59
`endif

// ===== src/rtcb_pkg.sv
package rtcb_pkg;
   // ****************************************************
   // calendar carriers
   // ****************************************************
   typedef struct packed {
      logic       pm;
      logic [5:0] hour;
      logic [6:0] min;
      logic [6:0] sec;
   } rtcb_time_s;
   typedef struct packed {
      logic [7:0] year;
      logic [2:0] wday;
      logic [4:0] month;
      logic [5:0] date;
   } rtcb_date_s;
   typedef struct packed {
      rtcb_date_s d;
      rtcb_time_s t;
   } rtcb_cal_s;
   typedef enum logic [1:0] {RTCB_SH_IDLE, RTCB_SH_ADV,
                             RTCB_SH_DLY} rtcb_shift_e;
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic       lvl;
      logic       chg;
      logic [2:0] cnt;
   } rtcb_pin_s;
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      rtcb_cal_s   cal;
      logic [7:0]  csec;
      logic [23:0] pre;
      logic [14:0] ctrl;
      logic [5:0]  flags;
      logic [31:0] alarm;
      rtcb_shift_e sst;
      logic [14:0] scnt;
      logic [9:0]  ppm;
      logic [19:0] acc;
      rtcb_cal_s   ts;
      logic [5:0]  refc;
      logic        upd;
      logic        wake;
   } rtcb_state_s;
   // bcd increment, wraps hi to lo; bit 8 is the carry
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo);
      logic [8:0] res;
      if (v == hi) begin
         res = {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         res = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         res = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
      return res;
   endfunction
endpackage

// ===== src/rtcb_pin_filt.sv
`timescale 1ns/100ps
`include "rtcb_defines.svh"
module rtcb_pin_filt (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       pin,
   input  wire logic [1:0] filt,
   output logic            lvl,
   output logic            chg
);
   rtcb_pkg::rtcb_pin_s r;
   rtcb_pkg::rtcb_pin_s n;
   logic [2:0]          need;

   // synchronise, then accept a level after 2^filt agreeing samples
   always_comb begin
      n = r;
      need = 3'((4'h1 << filt) - 4'h1);
      n.s1 = pin;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.chg = 1'b0;
      if ((r.s2 == r.s3) && (r.s3 != r.lvl)) begin
         if (r.cnt == need) begin
            n.lvl = r.s3;
            n.chg = 1'b1;
            n.cnt = 3'h0;
         end else begin
            n.cnt = r.cnt + 3'h1;
         end
      end else begin
         n.cnt = 3'h0;
      end
   end

   // state register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lvl = r.lvl;
   assign chg = r.chg;
endmodule // rtcb_pin_filt

// ===== src/rtcb_cal_adv.sv
`timescale 1ns/100ps
module rtcb_cal_adv (
   input  wire rtcb_pkg::rtcb_cal_s cur,
   input  wire logic                fmt12,
   output rtcb_pkg::rtcb_cal_s      nxt
);
   logic [8:0] s;
   logic [8:0] m;
   logic [8:0] h;
   logic [8:0] dt;
   logic [8:0] mo;
   logic [8:0] yr;
   logic       day_c;

   // last date of a month in bcd, leap years of a two-digit year
   function automatic logic [7:0] mlen(input logic [4:0] mon,
                                       input logic [7:0] y);
      logic leap;
      leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                        y[3:0] == 4'h8)) ||
             (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
      case (mon)
         5'h02: mlen = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: mlen = 8'h30;
         default: mlen = 8'h31;
      endcase
   endfunction

   // one second step with carries through to the year
   always_comb begin
      nxt = cur;
      day_c = 1'b0;
      h = '0;
      dt = '0;
      mo = '0;
      yr = '0;
      s = rtcb_pkg::bcd_inc({1'b0, cur.t.sec}, 8'h59, 8'h00);
      m = rtcb_pkg::bcd_inc({1'b0, cur.t.min}, 8'h59, 8'h00);
      nxt.t.sec = s[6:0];
      if (s[8]) begin
         nxt.t.min = m[6:0];
         if (m[8]) begin
            if (fmt12) begin
               if (cur.t.hour == 6'h11) begin
                  nxt.t.hour = 6'h12;
                  nxt.t.pm = ~cur.t.pm;
                  day_c = cur.t.pm;
               end else begin
                  h = rtcb_pkg::bcd_inc({2'b0, cur.t.hour}, 8'h12,
                                        8'h01);
                  nxt.t.hour = h[5:0];
               end
            end else begin
               h = rtcb_pkg::bcd_inc({2'b0, cur.t.hour}, 8'h23,
                                     8'h00);
               nxt.t.hour = h[5:0];
               nxt.t.pm = 1'b0;
               day_c = h[8];
            end
         end
      end
      if (day_c) begin
         nxt.d.wday = (cur.d.wday >= 3'h7) ? 3'h1 : cur.d.wday + 3'h1;
         dt = rtcb_pkg::bcd_inc({2'b0, cur.d.date},
                                mlen(cur.d.month, cur.d.year), 8'h01);
         nxt.d.date = dt[5:0];
         if (dt[8]) begin
            mo = rtcb_pkg::bcd_inc({3'b0, cur.d.month}, 8'h12, 8'h01);
            nxt.d.month = mo[4:0];
            if (mo[8]) begin
               yr = rtcb_pkg::bcd_inc(cur.d.year, 8'h99, 8'h00);
               nxt.d.year = yr[7:0];
            end
         end
      end
   end
endmodule // rtcb_cal_adv

// ===== src/rtcb_top.sv
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "rtcb_defines.svh"
// Notes on behaviour
// - five 32-bit backup words hold twenty bytes of application data.
// - backup words are never cleared by any reset or wake-up.
// - calendar counts hundredths to year, all fields in bcd.
// - hour counts and wraps in 12-hour or 24-hour format.
// - date wraps after 28, 29 on leap years, 30 or 31.
// - programmable alarm whose match raises the wake request.
// - shift write advances or delays by 1 to 32767 clock pulses.
// - signed ppm calibration adds or drops one pulse per million per ppm.
// - two filtered tamper inputs, each can raise the wake request.
// - timestamp captured on the stamp pin or on a tamper event.
// - timestamp event can raise the wake request.
// - optional 50 or 60 Hz reference drives the second tick.
// - registers decoded inside a 1 KB window, base 4000_2800.
module rtcb_top #(
   parameter int unsigned PRE_DIV = `RTCB_TICK_NS / `RTCB_CLK_NS,
   parameter int unsigned PPM_WIN = `RTCB_PPM_WIN
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [9:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic [1:0]  tamper_in,
   input  wire logic        stamp_in,
   input  wire logic        ref_in,
   output logic             wake
);
   // ****************************************************
   // declarations
   // ****************************************************
   rtcb_pkg::rtcb_state_s r;
   rtcb_pkg::rtcb_state_s n;
   rtcb_pkg::rtcb_cal_s   cal_inc;
   logic [31:0]           bkp_mem [`RTCB_BKP_NUM];
   logic [3:0]            pins;
   logic [3:0]            plvl;
   logic [3:0]            pchg;
   logic [9:0]            wa;
   logic                  wr_go;
   logic                  bkp_hit;
   logic [2:0]            bidx;
   logic [19:0]           acc_sum;
   logic                  cal_hit;
   logic [2:0]            up;
   logic [2:0]            dn;
   logic [23:0]           pre_sum;
   logic                  hund;
   logic [8:0]            cs;
   logic                  sec_tick;
   logic [1:0]            tevt;
   logic                  ts_evt;
   logic                  ts_cap;
   logic                  al_hit;
   logic [5:0]            fset;
   logic [5:0]            fclr;

   // ****************************************************
   // helper functions
   // ****************************************************
   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = o;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            res[8*k +: 8] = w[8*k +: 8];
         end
      end
      return res;
   endfunction

   // time fields to and from a register word
   function automatic logic [31:0] pack_t(input rtcb_pkg::rtcb_time_s t);
      return {9'h0, t.pm, t.hour, 1'b0, t.min, 1'b0, t.sec};
   endfunction

   function automatic rtcb_pkg::rtcb_time_s unpack_t(input logic [31:0] w);
      rtcb_pkg::rtcb_time_s t;
      t.pm = w[22];
      t.hour = w[21:16];
      t.min = w[14:8];
      t.sec = w[6:0];
      return t;
   endfunction

   // date fields to and from a register word
   function automatic logic [31:0] pack_d(input rtcb_pkg::rtcb_date_s d);
      return {8'h0, d.year, d.wday, d.month, 2'b0, d.date};
   endfunction

   function automatic rtcb_pkg::rtcb_date_s unpack_d(input logic [31:0] w);
      rtcb_pkg::rtcb_date_s d;
      d.year = w[23:16];
      d.wday = w[15:13];
      d.month = w[12:8];
      d.date = w[5:0];
      return d;
   endfunction

   // ****************************************************
   // pin conditioning and calendar step
   // ****************************************************
   assign pins = {ref_in, stamp_in, tamper_in};

   // tamper pins use the programmable filter, the others sync only
   for (genvar i = 0; i < 4; i++) begin : g_pin
      rtcb_pin_filt u_filt (
         .clock  (clock),
         .arst_n (arst_n),
         .pin    (pins[i]),
         .filt   ((i < 2) ? r.ctrl[`RTCB_C_FILT +: 2] : 2'b00),
         .lvl    (plvl[i]),
         .chg    (pchg[i])
      );
   end

   rtcb_cal_adv u_adv (
      .cur   (r.cal),
      .fmt12 (r.ctrl[`RTCB_C_FMT12]),
      .nxt   (cal_inc)
   );

   // ****************************************************
   // next-state logic
   // ****************************************************
   always_comb begin
      n = r;
      wa = {address[9:2], 2'b00};
      bkp_hit = (wa >= `RTCB_OFS_BKP0) && (wa < `RTCB_OFS_BKPE);
      bidx = 3'((wa - `RTCB_OFS_BKP0) >> 2);
      wr_go = write && r.ack;

      // bus answer one cycle after the request arrives
      n.ack = (read || write) && !r.ack;
      if (read && !r.ack) begin
         case (wa)
            `RTCB_OFS_TIME: n.rdata = pack_t(r.cal.t);
            `RTCB_OFS_DATE: n.rdata = pack_d(r.cal.d);
            `RTCB_OFS_CTRL: n.rdata = {17'h0, r.ctrl};
            `RTCB_OFS_STAT: begin
               n.rdata = {26'h0, r.flags};
               n.rdata[`RTCB_S_BUSY] = (r.sst != rtcb_pkg::RTCB_SH_IDLE);
            end
            `RTCB_OFS_SSEC: n.rdata = {24'h0, r.csec};
            `RTCB_OFS_ALRM: n.rdata = r.alarm;
            `RTCB_OFS_SHFT: n.rdata = {17'h0, r.scnt};
            `RTCB_OFS_CALR: n.rdata = {22'h0, r.ppm};
            `RTCB_OFS_TST:  n.rdata = pack_t(r.ts.t);
            `RTCB_OFS_TSD:  n.rdata = pack_d(r.ts.d);
            default: n.rdata = bkp_hit ? bkp_mem[bidx] : 32'h0;
         endcase
      end

      // ppm accumulator, one pulse per million per ppm
      acc_sum = r.acc + (r.ppm[9] ? 20'(-r.ppm) : {10'h0, r.ppm});
      cal_hit = (acc_sum >= 20'(PPM_WIN));
      n.acc = cal_hit ? acc_sum - 20'(PPM_WIN) : acc_sum;

      // shift correction stretches or shrinks the pulse count
      up = 3'h1 + {2'b0, r.sst == rtcb_pkg::RTCB_SH_ADV}
                + {2'b0, cal_hit && !r.ppm[9]};
      dn = {2'b0, r.sst == rtcb_pkg::RTCB_SH_DLY}
         + {2'b0, cal_hit && r.ppm[9]};
      pre_sum = r.pre + ((up > dn) ? {21'h0, up - dn} : 24'h0);
      hund = (pre_sum >= 24'(PRE_DIV));
      n.pre = hund ? pre_sum - 24'(PRE_DIV) : pre_sum;
      if (r.sst != rtcb_pkg::RTCB_SH_IDLE) begin
         n.scnt = r.scnt - 15'h1;
         if (r.scnt == 15'h1) begin
            n.sst = rtcb_pkg::RTCB_SH_IDLE;
         end
      end

      // hundredths of a second in bcd
      cs = rtcb_pkg::bcd_inc(r.csec, 8'h99, 8'h00);
      sec_tick = 1'b0;
      if (hund) begin
         n.csec = cs[7:0];
         sec_tick = cs[8] && !r.ctrl[`RTCB_C_REFEN];
      end

      // mains reference as the second source
      if (r.ctrl[`RTCB_C_REFEN] && pchg[3] && plvl[3]) begin
         if (r.refc == (r.ctrl[`RTCB_C_REF60] ? `RTCB_REF60_N
                                              : `RTCB_REF50_N)) begin
            n.refc = 6'h0;
            n.csec = 8'h00;
            n.pre = 24'h0;
            sec_tick = 1'b1;
         end else begin
            n.refc = r.refc + 6'h1;
         end
      end

      // second tick steps the whole calendar
      if (sec_tick) begin
         n.cal = cal_inc;
      end
      n.upd = sec_tick;

      // alarm compare after each calendar update
      al_hit = r.upd && r.ctrl[`RTCB_C_ALEN] &&
               (r.alarm[`RTCB_A_MSEC] || r.alarm[6:0] == r.cal.t.sec) &&
               (r.alarm[`RTCB_A_MMIN] || r.alarm[14:8] == r.cal.t.min) &&
               (r.alarm[`RTCB_A_MHR] || (r.alarm[21:16] == r.cal.t.hour
                  && r.alarm[22] == r.cal.t.pm)) &&
               (r.alarm[`RTCB_A_MDAT] || r.alarm[29:24] == r.cal.d.date);

      // tamper reaches its programmed active level
      for (int k = 0; k < 2; k++) begin
         tevt[k] = pchg[k] && r.ctrl[`RTCB_C_TPEN + k] &&
                   (plvl[k] == r.ctrl[`RTCB_C_TPLVL + k]);
      end

      // stamp pin rising edge or tamper event
      ts_evt = pchg[2] && plvl[2] && r.ctrl[`RTCB_C_TSEN];
      ts_cap = ts_evt || ((|tevt) && r.ctrl[`RTCB_C_TSTP]);
      if (ts_cap) begin
         n.ts = r.cal;
      end

      // sticky flags, a new event wins over a clear
      fset = '0;
      fset[`RTCB_S_ALRM] = al_hit;
      fset[`RTCB_S_TS] = ts_cap;
      fset[`RTCB_S_TAMP +: 2] = tevt;
      fset[`RTCB_S_TSOV] = ts_cap && r.flags[`RTCB_S_TS];
      fclr = '0;
      if (wr_go && wa == `RTCB_OFS_STAT && byteenable[0]) begin
         fclr = writedata[5:0];
         fclr[`RTCB_S_BUSY] = 1'b0;
      end
      n.flags = (r.flags & ~fclr) | fset;

      // register writes, taken when waitrequest is low
      if (wr_go) begin
         case (wa)
            `RTCB_OFS_TIME: begin
               n.cal.t = unpack_t(merge(pack_t(r.cal.t), writedata,
                                        byteenable));
               n.csec = 8'h00;
               n.pre = 24'h0;
            end
            `RTCB_OFS_DATE: begin
               n.cal.d = unpack_d(merge(pack_d(r.cal.d), writedata,
                                        byteenable));
            end
            `RTCB_OFS_CTRL: begin
               n.ctrl = 15'(merge({17'h0, r.ctrl}, writedata,
                                  byteenable));
            end
            `RTCB_OFS_ALRM: begin
               n.alarm = merge(r.alarm, writedata, byteenable);
            end
            `RTCB_OFS_SHFT: begin
               // ignored while busy or for a zero count
               if (r.sst == rtcb_pkg::RTCB_SH_IDLE &&
                   writedata[14:0] != 15'h0) begin
                  n.scnt = writedata[14:0];
                  n.sst = writedata[`RTCB_SH_ADVB] ?
                          rtcb_pkg::RTCB_SH_ADV : rtcb_pkg::RTCB_SH_DLY;
               end
            end
            `RTCB_OFS_CALR: begin
               n.ppm = 10'(merge({22'h0, r.ppm}, writedata, byteenable));
               n.acc = 20'h0;
            end
            default: begin
            end
         endcase
      end

      // wake request from enabled sticky events
      n.wake = (r.ctrl[`RTCB_C_WAKE] && r.flags[`RTCB_S_ALRM]) ||
               (r.ctrl[`RTCB_C_WAKE + 1] && r.flags[`RTCB_S_TS]) ||
               (r.ctrl[`RTCB_C_WAKE + 2] &&
                (|r.flags[`RTCB_S_TAMP +: 2]));
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.ctrl <= `RTCB_CTRL_RST;
         r.cal.d <= `RTCB_DATE_RST;
         r.sst <= rtcb_pkg::RTCB_SH_IDLE;
      end else begin
         r <= n;
      end
   end

   // ****************************************************
   // backup words, kept through every reset
   // ****************************************************
   // backup write with byte lanes, no reset term
   always_ff @(posedge clock) begin
      if (wr_go && bkp_hit) begin
         bkp_mem[bidx] <= merge(bkp_mem[bidx], writedata, byteenable);
      end
   end

   // bus and wake outputs
   assign waitrequest = (read || write) && !r.ack;
   assign readdata = r.rdata;
   assign wake = r.wake;
endmodule // rtcb_top

// ===== dv/rtcb_assertions.sv
`timescale 1ns/100ps
// ****************************************************
// bus handshake, read data and wake checks
// ****************************************************
module rtcb_assertions (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [9:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        wake
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // any request pending
   wire logic rq = read | write;
   a_wait_first: assert property ($rose(rq) |-> waitrequest)
      else $error("no wait cycle on new request");
   a_wait_one: assert property (rq && waitrequest |=> !waitrequest)
      else $error("wait longer than one cycle");
   a_idle_free: assert property (!rq |-> !waitrequest)
      else $error("wait without request");
   a_rdata_hold: assert property (
      $changed(readdata) |-> $past(read && waitrequest))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (
      read && waitrequest && address[9:2] > 8'h19
      |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_ssec_bcd: assert property (
      read && waitrequest && address[9:2] == 8'h04
      |=> readdata[31:8] == 24'h0 && readdata[3:0] < 4'ha
          && readdata[7:4] < 4'ha)
      else $error("hundredths not bcd");
   a_time_bcd: assert property (
      read && waitrequest && address[9:2] == 8'h00
      |=> readdata[3:0] < 4'ha && readdata[6:4] < 3'h6
          && readdata[11:8] < 4'ha && readdata[14:12] < 3'h6)
      else $error("time not bcd");
   a_month_range: assert property (
      read && waitrequest && address[9:2] == 8'h01
      |=> readdata[12:8] != 5'h0 && readdata[11:8] < 4'ha
          && readdata[12:8] < 5'h13)
      else $error("month out of range");
   a_wake_clear: assert property (
      $fell(wake)
      |-> $past(write) || $past(write, 2) || $past(write, 3))
      else $error("wake dropped without write");
   c_read: cover property (read && !waitrequest);
   c_write: cover property (write && !waitrequest);
   c_wake: cover property ($rose(wake));
endmodule // rtcb_assertions

bind rtcb_top rtcb_assertions i_chk (.clock(clock), .arst_n(arst_n),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .wake(wake));

// ===== dv/bcd_calendar_rtc_backup_tb_top.sv
`timescale 1ns/100ps
module bcd_calendar_rtc_backup_tb_top;
   logic        clock, arst_n, read, write, stamp_in, ref_in, wake;
   logic        waitrequest;
   logic [9:0]  address;
   logic [31:0] writedata, readdata, q;
   logic [3:0]  byteenable;
   logic [1:0]  tamper_in;
   int          failures, n_checks, i, n;
   // ctrl, time in, date in, time out, date out
   logic [31:0] cal_t [8][5] = '{
      '{0, 32'h0023_5959, 32'h0001_2228, 0, 32'h0001_4301},
      '{0, 32'h0023_5959, 32'h0004_2228, 0, 32'h0004_4229},
      '{0, 32'h0023_5959, 32'h0004_2229, 0, 32'h0004_4301},
      '{0, 32'h0023_5959, 32'h0001_2430, 0, 32'h0001_4501},
      '{0, 32'h0023_5959, 32'h0001_3231, 0, 32'h0002_4101},
      '{1, 32'h0011_5959, 32'h0001_2215, 32'h0052_0000, 32'h0001_2215},
      '{1, 32'h0052_5959, 32'h0001_2215, 32'h0041_0000, 32'h0001_2215},
      '{1, 32'h0051_5959, 32'h0001_2215, 32'h0012_0000, 32'h0001_4216}};

   rtcb_top #(.PRE_DIV(4), .PPM_WIN(100)) i_dut (.clock(clock),
      .arst_n(arst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .tamper_in(tamper_in),
      .stamp_in(stamp_in), .ref_in(ref_in), .wake(wake));

   // 10 MHz clock
   always #50 clock = ~clock;

   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one bus cycle, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [9:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         failures++;
         stop_test();
      end
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      acc(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   task automatic wait_wake();
      int k;
      for (k = 0; k < 1000 && wake !== 1'b1; k++) @(posedge clock);
      chk({31'h0, wake}, 32'h1);
      if (wake !== 1'b1) stop_test();
   endtask

   // main sequence
   initial begin
      {clock, arst_n, read, write, stamp_in, ref_in, tamper_in} = '0;
      {address, writedata, failures, n_checks} = '0;
      byteenable = 4'hf;
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rdc(10'h008, 32'h0);
      rdc(10'h004, 32'h0000_2101);
      wr(10'h100, 32'hffff_ffff);
      rdc(10'h100, 32'h0);
      for (i = 0; i < 5; i++) wr(10'h050 + 10'(4 * i), 32'h5a5a_0000 + 32'(i));
      byteenable <= 4'h1;
      wr(10'h050, 32'hffff_ffee);
      byteenable <= 4'hf;
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rdc(10'h050, 32'h5a5a_00ee);
      for (i = 1; i < 5; i++)
         rdc(10'h050 + 10'(4 * i), 32'h5a5a_0000 + 32'(i));
      $display("reset and backup done");
      for (i = 0; i < 8; i++) begin
         wr(10'h008, cal_t[i][0]);
         wr(10'h004, cal_t[i][2]);
         wr(10'h000, cal_t[i][1]);
         q = cal_t[i][1];
         for (n = 0; n < 300 && q === cal_t[i][1]; n++) acc(1'b0, 10'h000, 32'h0, q);
         chk(q, cal_t[i][3]);
         rdc(10'h004, cal_t[i][4]);
      end
      $display("calendar done");
      wr(10'h008, 32'h0000_1002);
      wr(10'h014, 32'h4080_8001);
      wr(10'h000, 32'h0);
      chk({31'h0, wake}, 32'h0);
      wait_wake();
      rdc(10'h00c, 32'h1);
      wr(10'h00c, 32'h1);
      repeat (3) @(posedge clock);
      chk({31'h0, wake}, 32'h0);
      $display("alarm done");
      wr(10'h008, 32'h0000_2100);
      wr(10'h000, 32'h0012_3456);
      wr(10'h004, 32'h0001_2215);
      stamp_in <= 1'b1;
      wait_wake();
      stamp_in <= 1'b0;
      rdc(10'h020, 32'h0012_3456);
      rdc(10'h024, 32'h0001_2215);
      rdc(10'h00c, 32'h2);
      stamp_in <= 1'b1;
      repeat (12) @(posedge clock);
      rdc(10'h00c, 32'h22);
      stamp_in <= 1'b0;
      for (i = 0; i < 2; i++) begin
         wr(10'h00c, 32'h3f);
         wr(10'h008, 32'h0000_4200 | (32'h50 << i) | (i ? 32'hc00 : 32'h0));
         if (i) begin
            tamper_in[1] <= 1'b1;
            repeat (4) @(posedge clock);
            tamper_in[1] <= 1'b0;
            repeat (16) @(posedge clock);
            rdc(10'h00c, 32'h0);
         end
         tamper_in[i] <= 1'b1;
         wait_wake();
         tamper_in <= 2'b00;
         rdc(10'h00c, (32'h4 << i) | 32'h2);
      end
      wr(10'h00c, 32'h3f);
      $display("stamp and tamper done");
      wr(10'h018, 32'h8000_0000);
      rdc(10'h00c, 32'h0);
      wr(10'h018, 32'h8000_0020);
      rdc(10'h00c, 32'h10);
      repeat (40) @(posedge clock);
      rdc(10'h00c, 32'h0);
      rdc(10'h018, 32'h0);
      wr(10'h018, 32'h0000_7fff);
      acc(1'b0, 10'h018, 32'h0, q);
      chk(32'(q > 32'h7ff0 && q <= 32'h7fff), 32'h1);
      wr(10'h01c, 32'h0000_03fb);
      rdc(10'h01c, 32'h0000_03fb);
      $display("shift and calibration done");
      for (i = 0; i < 2; i++) begin
         wr(10'h008, 32'h4 | (32'(i) << 3));
         wr(10'h000, 32'h0);
         for (n = 0; n < (i ? 60 : 50); n++) begin
            if (n == (i ? 59 : 49)) begin
               repeat (8) @(posedge clock);
               rdc(10'h000, 32'h0);
            end
            ref_in <= 1'b1;
            repeat (2) @(posedge clock);
            ref_in <= 1'b0;
            repeat (2) @(posedge clock);
         end
         repeat (8) @(posedge clock);
         rdc(10'h000, 32'h1);
      end
      $display("reference done");
      stop_test();
   end
endmodule // bcd_calendar_rtc_backup_tb_top
